// ### hdl/pcdc_pkg.sv
// constants, types and states shared by the display control files
`default_nettype none
package pcdc_pkg;
   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_MHZ            = 10;
   localparam int T_PNT_CPU_NS       = 3200;
   localparam int T_PNT_ALL_NS       = 23000;
   localparam int T_CHR_CPU_FAST_NS  = 4800;
   localparam int T_CHR_CPU_SLOW_NS  = 6400;
   localparam int T_SCAN_FIRST_NS    = 20000;
   localparam int T_DOT_DARK_NS      = 1000;
   localparam int T_DOT_LIT_NS       = 3000;
   // least times round up to whole cycles
   localparam int PNT_CPU_CYC   = (T_PNT_CPU_NS * CLK_MHZ + 999) / 1000;
   localparam int PNT_ALL_CYC   = (T_PNT_ALL_NS * CLK_MHZ + 999) / 1000;
   localparam int CHR_FAST_CYC  = (T_CHR_CPU_FAST_NS * CLK_MHZ + 999) / 1000;
   localparam int CHR_SLOW_CYC  = (T_CHR_CPU_SLOW_NS * CLK_MHZ + 999) / 1000;
   localparam int SCAN_1ST_CYC  = (T_SCAN_FIRST_NS * CLK_MHZ + 999) / 1000;
   localparam int DOT_DARK_CYC  = (T_DOT_DARK_NS * CLK_MHZ + 999) / 1000;
   localparam int DOT_LIT_CYC   = (T_DOT_LIT_NS * CLK_MHZ + 999) / 1000;
   localparam int TCNT_W        = 9;
   // ****************************************************************
   // data layout
   // ****************************************************************
   typedef logic [11:0] pcdc_word_t;
   typedef logic [8:0]  pcdc_crd_t;
   localparam logic [9:0]  IDX_INC        = 10'h001;
   localparam int          SF_SIZE_BIT    = 7;
   localparam logic [4:0]  Y_LOW_FULL     = 5'h18;
   localparam logic [3:0]  Y_LOW_HALF     = 4'hC;
   localparam pcdc_word_t  X_INC_FULL     = 12'h008;
   localparam pcdc_word_t  X_INC_HALF     = 12'h004;
   localparam pcdc_crd_t   STEP_FULL      = 9'h004;
   localparam pcdc_crd_t   STEP_HALF      = 9'h002;
   localparam logic [3:0]  COL_LAST_IDX   = 4'h5;
   localparam logic [3:0]  PAT_LAST_IDX   = 4'hB;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [2:0]  A_CTRL   = 3'h0;
   localparam logic [2:0]  A_STAT   = 3'h1;
   localparam logic [2:0]  A_XBUF   = 3'h2;
   localparam logic [2:0]  A_YBUF   = 3'h3;
   localparam logic [2:0]  A_PAT    = 3'h4;
   localparam int          CTRL_SIZE_BIT = 0;
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_CPU   = 3'b001,
      ST_PWAIT = 3'b010,
      ST_REACH = 3'b011,
      ST_DOT   = 3'b100
   } pcdc_state_e;
endpackage
`default_nettype wire

// ### hdl/pcdc_ctl_if.sv
// links the sequencer to its interval timer and pattern scanner
`timescale 1ns/1ps
`default_nettype none
interface pcdc_ctl_if
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce
);
   logic        tmr_load;
   logic [8:0]  tmr_val;
   logic        tmr_exp;
   logic        pat_load;
   logic [11:0] pat_in;
   logic        pat_step;
   logic        pat_bit;
   logic        pat_nxt;
   logic        pat_last;
   logic        pat_col_end;
   logic [11:0] pat_word;
   modport tmr  (input clk, rst_n, ce, tmr_load, tmr_val, output tmr_exp);
   modport scan (input clk, rst_n, ce, pat_load, pat_in, pat_step,
                 output pat_bit, pat_nxt, pat_last, pat_col_end, pat_word);
   modport ctl  (output tmr_load, tmr_val, pat_load, pat_in, pat_step,
                 input tmr_exp, pat_bit, pat_nxt, pat_last, pat_col_end, pat_word);
endinterface
`default_nettype wire

// ### hdl/pcdc_tmr.sv
// interval down counter that flags its last cycle
`timescale 1ns/1ps
`default_nettype none
module pcdc_tmr
(
   pcdc_ctl_if.tmr t
);
   import pcdc_pkg::*;
   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   // expires in the cycle the count reaches one, so a reload loses no cycle
   assign t.tmr_exp = (cnt_r == 9'h001);
   assign cnt_nxt   = t.tmr_load ? t.tmr_val :
                      (cnt_r != 9'h000) ? cnt_r - 9'h001 : cnt_r;
   always_ff @(posedge t.clk or negedge t.rst_n)
   begin
      if (!t.rst_n)
         cnt_r <= 9'h000;
      else if (t.ce)
         cnt_r <= cnt_nxt;
   end
endmodule
`default_nettype wire

// ### hdl/pcdc_scan.sv
// intensification register and pattern bit walker
`timescale 1ns/1ps
`default_nettype none
module pcdc_scan
(
   pcdc_ctl_if.scan s
);
   import pcdc_pkg::*;
   pcdc_word_t pat_r;
   pcdc_word_t shf_r;
   logic [3:0] idx_r;
   assign s.pat_bit     = shf_r[0];
   assign s.pat_nxt     = shf_r[1];
   assign s.pat_last    = (idx_r == PAT_LAST_IDX);
   assign s.pat_col_end = (idx_r == COL_LAST_IDX);
   assign s.pat_word    = pat_r;
   always_ff @(posedge s.clk or negedge s.rst_n)
   begin
      if (!s.rst_n)
      begin
         pat_r <= 12'h000;
         shf_r <= 12'h000;
         idx_r <= 4'h0;
      end
      else if (s.ce)
      begin
         if (s.pat_load)
         begin
            pat_r <= s.pat_in;
            shf_r <= s.pat_in;
            idx_r <= 4'h0;
         end
         else if (s.pat_step)
         begin
            shf_r <= {1'b0, shf_r[11:1]};
            idx_r <= idx_r + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/pcdc_top.sv
// buffered point and character column display control
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcdc_top
#(
   parameter int TW = pcdc_pkg::TCNT_W
)
(
   input  wire logic                 SYS_CLK,
   input  wire logic                 RST_N,
   input  wire logic                 CE,
   input  wire logic                 IO_PRESET,
   input  wire logic                 CMD_PNT_REQ,
   input  wire logic                 CMD_CHR_REQ,
   input  wire logic                 CMD_SF,
   input  wire pcdc_pkg::pcdc_word_t PWR_IN,
   input  wire pcdc_pkg::pcdc_word_t IDX_IN,
   input  wire logic                 INDIRECT,
   input  wire logic                 PTR_ZERO,
   input  wire logic                 CHR_CHAN,
   input  wire pcdc_pkg::pcdc_word_t PATTERN_IN,
   input  wire pcdc_pkg::pcdc_word_t XREG_IN,
   input  wire logic [2:0]           ADDR,
   input  wire pcdc_pkg::pcdc_word_t WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output var  pcdc_pkg::pcdc_word_t RDATA,
   output var  logic                 CPU_DONE,
   output var  logic                 STALL,
   output var  logic                 BUSY,
   output var  pcdc_pkg::pcdc_word_t PWR_OUT,
   output var  pcdc_pkg::pcdc_word_t IDX_OUT,
   output var  pcdc_pkg::pcdc_word_t XREG_OUT,
   output var  pcdc_pkg::pcdc_crd_t  X_BUF,
   output var  pcdc_pkg::pcdc_crd_t  Y_BUF,
   output var  logic [1:0]           INTENS,
   output var  logic                 SIZE_FULL
);
   import pcdc_pkg::*;

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if ((1 << TW) <= PNT_ALL_CYC || TW > 9)
   begin : g_chk
      $error("timer width cannot hold the longest interval");
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [8:0] cyc(input int n);
      return n[8:0];
   endfunction

   function automatic pcdc_crd_t step_of(input logic full);
      return full ? STEP_FULL : STEP_HALF;
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   pcdc_state_e state_r;
   pcdc_state_e state_nxt;
   logic        is_chr_r;
   logic        chan_r;
   logic        size_r;
   pcdc_crd_t   xbuf_r;
   pcdc_crd_t   ybuf_r;
   pcdc_crd_t   ystart_r;
   logic        done_r;
   logic        stall_r;
   logic        busy_r;
   pcdc_word_t  pwr_r;
   pcdc_word_t  idx_r;
   pcdc_word_t  xreg_r;
   logic [1:0]  intens_r;
   pcdc_word_t  rdata_r;

   pcdc_ctl_if u_if (.clk(SYS_CLK), .rst_n(RST_N), .ce(CE));
   pcdc_tmr    u_tmr (.t(u_if.tmr));
   pcdc_scan   u_scan (.s(u_if.scan));

   // ****************************************************************
   // command decode
   // ****************************************************************
   wire        idle     = (state_r == ST_IDLE);
   wire        pnt_acc  = idle && CMD_PNT_REQ;
   wire        chr_acc  = idle && CMD_CHR_REQ && !CMD_PNT_REQ;
   wire        fast_chr = INDIRECT && PTR_ZERO;
   wire        exp      = u_if.tmr_exp;
   wire [9:0]  idx_low  = IDX_IN[9:0] + IDX_INC;
   wire pcdc_word_t idx_eff = INDIRECT ? {IDX_IN[11:10], idx_low} : IDX_IN;
   wire pcdc_word_t x_inc   = size_r ? X_INC_FULL : X_INC_HALF;
   wire pcdc_word_t xreg_new = XREG_IN + x_inc;
   wire pcdc_crd_t  y_full  = {PWR_IN[8:5], Y_LOW_FULL};
   wire pcdc_crd_t  y_half  = {PWR_IN[8:4], Y_LOW_HALF};
   wire pcdc_crd_t  y_chr   = size_r ? y_full : y_half;
   wire        dot_end  = (state_r == ST_DOT) && exp;
   wire        scan_fin = dot_end && u_if.pat_last;
   wire        dot_lit  = u_if.pat_nxt;
   wire        sf_size  = PWR_IN[SF_SIZE_BIT];
   // a request still held through its own processor phase is not waiting
   wire        own_hold = (state_r == ST_CPU) || done_r;

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb
   begin
      state_nxt      = state_r;
      u_if.tmr_load  = 1'b0;
      u_if.tmr_val   = 9'h000;
      u_if.pat_load  = chr_acc;
      u_if.pat_in    = PATTERN_IN;
      u_if.pat_step  = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            if (pnt_acc)
            begin
               state_nxt     = ST_CPU;
               u_if.tmr_load = 1'b1;
               u_if.tmr_val  = cyc(PNT_CPU_CYC - 1);
            end
            else if (chr_acc)
            begin
               state_nxt     = ST_CPU;
               u_if.tmr_load = 1'b1;
               u_if.tmr_val  = fast_chr ? cyc(CHR_FAST_CYC - 1)
                                        : cyc(CHR_SLOW_CYC - 1);
            end
         end
         ST_CPU:
         begin
            if (exp)
            begin
               u_if.tmr_load = 1'b1;
               if (is_chr_r)
               begin
                  state_nxt    = ST_REACH;
                  u_if.tmr_val = cyc(SCAN_1ST_CYC);
               end
               else
               begin
                  state_nxt    = ST_PWAIT;
                  u_if.tmr_val = cyc(PNT_ALL_CYC - PNT_CPU_CYC);
               end
            end
         end
         ST_PWAIT:
         begin
            if (exp)
               state_nxt = ST_IDLE;
         end
         ST_REACH:
         begin
            if (exp)
            begin
               state_nxt     = ST_DOT;
               u_if.tmr_load = 1'b1;
               u_if.tmr_val  = u_if.pat_bit ? cyc(DOT_LIT_CYC)
                                            : cyc(DOT_DARK_CYC);
            end
         end
         ST_DOT:
         begin
            if (scan_fin)
               state_nxt = ST_IDLE;
            else if (exp)
            begin
               u_if.pat_step = 1'b1;
               u_if.tmr_load = 1'b1;
               u_if.tmr_val  = dot_lit ? cyc(DOT_LIT_CYC)
                                       : cyc(DOT_DARK_CYC);
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         state_r <= ST_IDLE;
      else if (CE)
         state_r <= state_nxt;
   end

   // ****************************************************************
   // coordinate buffers and processor results
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         is_chr_r <= 1'b0;
         chan_r   <= 1'b0;
         xbuf_r   <= 9'h000;
         ybuf_r   <= 9'h000;
         ystart_r <= 9'h000;
         pwr_r    <= 12'h000;
         idx_r    <= 12'h000;
         xreg_r   <= 12'h000;
      end
      else if (CE)
      begin
         if (pnt_acc)
         begin
            is_chr_r <= 1'b0;
            chan_r   <= idx_eff[11];
            xbuf_r   <= idx_eff[8:0];
            ybuf_r   <= PWR_IN[8:0];
            idx_r    <= idx_eff;
            pwr_r    <= PWR_IN;
         end
         else if (chr_acc)
         begin
            is_chr_r <= 1'b1;
            chan_r   <= CHR_CHAN;
            xbuf_r   <= xreg_new[8:0];
            ybuf_r   <= y_chr;
            ystart_r <= y_chr;
            pwr_r    <= size_r ? {PWR_IN[11:5], Y_LOW_FULL}
                               : {PWR_IN[11:4], Y_LOW_HALF};
            xreg_r   <= xreg_new;
         end
         else if (u_if.pat_step)
         begin
            // column 0 runs downward from the start row, column 1 sits one step right
            if (u_if.pat_col_end)
            begin
               ybuf_r <= ystart_r;
               xbuf_r <= xbuf_r + step_of(size_r);
            end
            else
               ybuf_r <= ybuf_r - step_of(size_r);
         end
      end
   end

   // ****************************************************************
   // handshake, intensify and size flag
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         done_r   <= 1'b0;
         stall_r  <= 1'b0;
         busy_r   <= 1'b0;
         intens_r <= 2'b00;
         size_r   <= 1'b1;
      end
      else if (CE)
      begin
         done_r  <= (state_r == ST_CPU) && exp;
         busy_r  <= (state_nxt != ST_IDLE);
         stall_r <= !idle && !own_hold && (CMD_PNT_REQ || CMD_CHR_REQ);
         // a point shows for its whole display time; a character only on lit dots
         if (pnt_acc)
            intens_r <= idx_eff[11] ? 2'b10 : 2'b01;
         else if ((state_r == ST_REACH && exp && u_if.pat_bit) ||
                  (dot_end && !scan_fin && dot_lit))
            intens_r <= chan_r ? 2'b10 : 2'b01;
         else if ((state_r == ST_PWAIT && exp) || dot_end)
            intens_r <= 2'b00;
         // preset beats a software write in the same cycle
         if (IO_PRESET)
            size_r <= 1'b1;
         else if (CMD_SF)
            size_r <= sf_size;
         else if (WR && ADDR == A_CTRL)
            size_r <= WDATA[CTRL_SIZE_BIT];
      end
   end

   // ****************************************************************
   // register read port
   // ****************************************************************
   wire pcdc_word_t stat_w = {5'h00, chan_r, is_chr_r, state_r, 1'b0, busy_r};
   wire pcdc_word_t rd_mux = (ADDR == A_CTRL) ? {11'h000, size_r} :
                             (ADDR == A_STAT) ? stat_w :
                             (ADDR == A_XBUF) ? {3'h0, xbuf_r} :
                             (ADDR == A_YBUF) ? {3'h0, ybuf_r} :
                             (ADDR == A_PAT)  ? u_if.pat_word : 12'h000;

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         rdata_r <= 12'h000;
      else if (CE)
         rdata_r <= RD ? rd_mux : 12'h000;
   end

   assign RDATA     = rdata_r;
   assign CPU_DONE  = done_r;
   assign STALL     = stall_r;
   assign BUSY      = busy_r;
   assign PWR_OUT   = pwr_r;
   assign IDX_OUT   = idx_r;
   assign XREG_OUT  = xreg_r;
   assign X_BUF     = xbuf_r;
   assign Y_BUF     = ybuf_r;
   assign INTENS    = intens_r;
   assign SIZE_FULL = size_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_PNT_CPU: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      pnt_acc |-> ##32 done_r)
      else $error("point processor phase not 32 cycles");
   AST_PNT_ALL: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      pnt_acc |-> ##229 busy_r ##1 !busy_r)
      else $error("point display not 230 cycles");
   AST_CHR_FAST: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (chr_acc && fast_chr) |-> ##48 done_r)
      else $error("fast character phase wrong");
   AST_CHR_SLOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (chr_acc && !fast_chr) |-> ##48 !done_r ##16 done_r)
      else $error("slow character phase wrong");
   AST_STALL: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (busy_r && (CMD_PNT_REQ || CMD_CHR_REQ) && state_r != ST_CPU && !done_r)
         |=> stall_r && $stable(idx_r) && $stable(pwr_r))
      else $error("command taken while busy");
   AST_IDX_INC: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (pnt_acc && INDIRECT) |=> idx_r[11:10] == $past(IDX_IN[11:10])
         && idx_r[9:0] == $past(IDX_IN[9:0]) + 10'h001)
      else $error("index increment wrong");
   AST_CHAN: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      pnt_acc |=> intens_r[1] == $past(idx_eff[11]) && intens_r[0] != intens_r[1])
      else $error("point channel wrong");
   AST_CHR_Y: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (chr_acc && size_r) |=> ybuf_r[4:0] == 5'h18 && pwr_r[4:0] == 5'h18)
      else $error("full size start row wrong");
   AST_PAT: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      chr_acc |=> u_if.pat_word == $past(PATTERN_IN))
      else $error("pattern not captured");
   AST_DOT: assert property (@(posedge SYS_CLK) disable iff (!RST_N || !CE)
      (state_r == ST_REACH && exp && !u_if.pat_bit) |-> ##10 u_if.pat_step)
      else $error("dark dot not one microsecond");
endmodule
`default_nettype wire

// ### tb/pcdc_crt.sv
// crt monitor model: tallies lit time and the lit extent of the beam
`timescale 1ns/1ps
`default_nettype none
module pcdc_crt
(
   input  wire logic                clk,
   input  wire logic                clr,
   input  wire pcdc_pkg::pcdc_crd_t x,
   input  wire pcdc_pkg::pcdc_crd_t y,
   input  wire logic [1:0]          intens,
   output var  logic [11:0]         lit,
   output var  pcdc_pkg::pcdc_crd_t xlo,
   output var  pcdc_pkg::pcdc_crd_t xhi,
   output var  pcdc_pkg::pcdc_crd_t ylo,
   output var  pcdc_pkg::pcdc_crd_t yhi,
   output var  logic [1:0]          ch
);
   import pcdc_pkg::*;
   // ************
   // beam marks
   // ************
   // the tube only leaves a mark while a channel is intensified
   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         lit <= 12'h000;
         xlo <= 9'h1FF;
         xhi <= 9'h000;
         ylo <= 9'h1FF;
         yhi <= 9'h000;
         ch  <= 2'h0;
      end
      else if (intens != 2'h0)
      begin
         lit <= lit + 12'h001;
         xlo <= (x < xlo) ? x : xlo;
         xhi <= (x > xhi) ? x : xhi;
         ylo <= (y < ylo) ? y : ylo;
         yhi <= (y > yhi) ? y : yhi;
         ch  <= intens;
      end
   end
endmodule
`default_nettype wire

// ### tb/pcdc_top_tb.sv
// self-checking bench for the point and character display control
`timescale 1ns/1ps
`default_nettype none
module pcdc_top_tb;
   import pcdc_pkg::*;
   logic clk = 0, rst_n = 0, pre = 0, pr = 0, cr = 0, sf = 0, ind = 0, pz = 0;
   logic chan = 0, wr = 0, rd = 0, clr = 0, done, stall, busy, full, st;
   pcdc_word_t pwr = 0, idx = 0, pat = 0, xr = 0, wd = 0, rdata, pwro, idxo, xro;
   pcdc_crd_t xb, yb, xlo, xhi, ylo, yhi;
   logic [2:0] addr = 0;
   logic [1:0] intens, ch;
   logic [11:0] lit;
   int err_total = 0, checked = 0, n, m;
   always #50 clk = ~clk;
   pcdc_top pcdc_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .CE(1'b1), .IO_PRESET(pre),
      .CMD_PNT_REQ(pr), .CMD_CHR_REQ(cr), .CMD_SF(sf), .PWR_IN(pwr), .IDX_IN(idx),
      .INDIRECT(ind), .PTR_ZERO(pz), .CHR_CHAN(chan), .PATTERN_IN(pat), .XREG_IN(xr),
      .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .CPU_DONE(done),
      .STALL(stall), .BUSY(busy), .PWR_OUT(pwro), .IDX_OUT(idxo), .XREG_OUT(xro),
      .X_BUF(xb), .Y_BUF(yb), .INTENS(intens), .SIZE_FULL(full));
   pcdc_crt pcdc_crt_inst (.clk(clk), .clr(clr), .x(xb), .y(yb), .intens(intens),
      .lit(lit), .xlo(xlo), .xhi(xhi), .ylo(ylo), .yhi(yhi), .ch(ch));
   // ****************
   // shared tasks
   // ****************
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_io(input logic w, input logic [2:0] a, input pcdc_word_t d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic go(input pcdc_word_t p, i, input logic f, z, c, input pcdc_word_t t, x);
      @(posedge clk);
      pwr <= p;
      idx <= i;
      ind <= f;
      pz <= z;
      chan <= c;
      pat <= t;
      xr <= x;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   // the request is held until the processor phase ends, then dropped
   task automatic cmd(input logic is_chr, input logic wt);
      n = 0;
      m = 0;
      st = 0;
      @(posedge clk);
      if (is_chr) cr <= 1'b1;
      else pr <= 1'b1;
      while (done !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         #1 n++;
         if (stall === 1'b1) st = 1;
      end
      @(posedge clk);
      pr <= 1'b0;
      cr <= 1'b0;
      #1 m = 1;
      while (wt && busy !== 1'b0 && m < 3000)
      begin
         @(posedge clk);
         #1 m++;
      end
      if (n >= 3000 || m >= 3000)
      begin
         err_total++;
         wrap_up();
      end
   endtask
   // ****************
   // scenarios
   // ****************
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk(12'(full), 12'h001);
      chk(12'(busy), 12'h000);
      // indirect point: low ten bits wrap, top two kept
      go(12'h1A5, 12'h7FF, 1, 0, 0, 12'h000, 12'h000);
      cmd(0, 1);
      chk(idxo, 12'h400);
      chk(12'(xb), 12'h000);
      chk(12'(yhi), 12'h1A5);
      chk(12'(ch), 12'h001);
      chk(12'(n), 12'h020);
      chk(12'(m), 12'h0C6);
      chk(12'(st), 12'h000);
      reg_io(0, 3'h3, 12'h000);
      chk(rdata, 12'h1A5);
      reg_io(0, 3'h7, 12'h000);
      chk(rdata, 12'h000);
      // direct point, then a character that has to wait for it
      go(12'h0AB, 12'h8AB, 0, 0, 0, 12'h000, 12'h000);
      cmd(0, 0);
      chk(12'(xb), 12'h0AB);
      chk(idxo, 12'h8AB);
      go(12'hF3C, 12'h000, 0, 0, 0, 12'hFFE, 12'hFFC);
      cmd(1, 1);
      chk(12'(st), 12'h001);
      chk(pwro, 12'hF38);
      chk(xro, 12'h004);
      @(posedge clk);
      sf <= 1'b1;
      @(posedge clk);
      sf <= 1'b0;
      #1 chk(12'(full), 12'h000);
      // half size, single lit dot proves bit 0 is shown first
      go(12'h2B7, 12'h000, 1, 1, 1, 12'h001, 12'h100);
      cmd(1, 1);
      chk(pwro, 12'h2BC);
      chk(xro, 12'h104);
      chk(12'(n), 12'h030);
      chk(12'(m > 335 && m < 343), 12'h001);
      chk(lit, 12'h01E);
      chk({xlo, 3'h0} ^ {xhi, 3'h0}, 12'h000);
      chk(12'(xlo), 12'h104);
      chk(12'(ylo), 12'h0BC);
      chk(12'(yhi), 12'h0BC);
      chk(12'(ch), 12'h002);
      @(posedge clk);
      pre <= 1'b1;
      @(posedge clk);
      pre <= 1'b0;
      #1 chk(12'(full), 12'h001);
      // full size, every point lit
      go(12'h0A0, 12'h000, 1, 0, 0, 12'hFFF, 12'h010);
      cmd(1, 1);
      chk(pwro, 12'h0B8);
      chk(12'(n), 12'h040);
      chk(12'(m > 555 && m < 563), 12'h001);
      chk(lit, 12'h168);
      chk(12'(xlo), 12'h018);
      chk(12'(xhi), 12'h01C);
      chk(12'(yhi), 12'h0B8);
      chk(12'(ylo), 12'h0A4);
      reg_io(1, 3'h0, 12'h000);
      chk(12'(full), 12'h000);
      reg_io(0, 3'h0, 12'h000);
      chk(rdata, 12'h000);
      reg_io(1, 3'h0, 12'h001);
      chk(12'(full), 12'h001);
      reg_io(0, 3'h1, 12'h000);
      chk(12'(rdata[0]), 12'h000);
      wrap_up();
   end
endmodule
`default_nettype wire
